// ===== shared/pitch_lag_regs.vh
// constants of the pitch lag trajectory and voicing mode stage
// assumes one 40 MHz clock; upstream loads all tables before start
`ifndef PITCH_LAG_REGS_VH
`define PITCH_LAG_REGS_VH
// lag table level limits and window spans
`define LV_LO 8'h00
`define LV_HI 8'hFF
`define FW_DN 8'h07
`define FW_UP 8'h06
`define BW_DN 8'h06
`define BW_UP 8'h07
// subframe length, history offset, coefficient bases
`define NS 40
`define HOFF 216
`define GOFF 60
// gain thresholds as 256*10^(dB/10): 1.7, 3.5, 7.0 dB
`define K17 12'h17B
`define K35 12'h23D
`define K70 12'h503
// 0.4 in Q15
`define LAM_K 17'h03333
// load selects
`define W_CI 4'h0
`define W_GI 4'h1
`define W_PK 4'h2
`define W_PN 4'h3
`define W_R0 4'h4
`define W_C0 4'h5
`define W_G0 4'h6
`define W_CP 4'h7
`define W_GP 4'h8
`define W_LP 4'h9
`define W_LT 4'hA
`define W_CF 4'hB
`define W_HH 4'hC
`define W_XW 4'hD
`define W_ZR 4'hE
`define W_HS 4'hF
// read selects
`define R_ACB 2'h0
`define R_BPP 2'h1
`define R_TGT 2'h2
`endif

// ===== verilog/pitch_lag_search_mode_select.v
// frame lag trajectory search, voicing mode and closed-loop lag search
// upstream loads peaks, correlation tables and filters on the same clock
// Behaviour
// - anchor highest uncrossed peak, two per subframe
// - anchor error energy loads trajectory accumulator
// - forward window minus seven to plus six
// - backward window minus six to plus seven
// - clip windows to table level range
// - maximise C over root G, add error
// - forward to last, backward to first
// - store lags and error, count trajectories
// - pick stored trajectory with least error
// - subframe gain from selected lag
// - frame gain from best open-loop peaks
// - mode thresholds 1.7, 3.5, 7.0 dB
// - three closed-loop levels, two at edges
// - mode zero skips closed-loop search
// - extend history, 10-tap filter, ascending
// - phase six times fraction, zero copies
// - codebook output is last 40 samples
// - closed-loop pick over candidate list only
// - harmonic weighting with 0.4 C over G
// - harmonic delay through open-loop filter
// - target spectral only in mode zero
// - filtered adaptive vector before codebook search
// - pitch lags held in sixths
`timescale 1ns/1ps
`include "pitch_lag_regs.vh"
module pitch_lag_search_mode_select (
   input wire clk,
   input wire sys_rst,
   input wire start,
   input wire wr_en,
   input wire [3:0] wr_sel,
   input wire [9:0] wr_addr,
   input wire [31:0] wr_data,
   input wire [1:0] rd_sel,
   input wire [7:0] rd_addr,
   output reg [15:0] rd_data,
   output wire busy,
   output wire done,
   output wire [1:0] mode,
   output wire [31:0] traj_lags,
   output wire [31:0] cl_lags,
   output wire [3:0] traj_count
);
localparam [9:0] S_IDLE = 10'h001;
localparam [9:0] S_ANC = 10'h002;
localparam [9:0] S_WIN = 10'h004;
localparam [9:0] S_STO = 10'h008;
localparam [9:0] S_SEL = 10'h010;
localparam [9:0] S_MOD = 10'h020;
localparam [9:0] S_TGT = 10'h040;
localparam [9:0] S_GEN = 10'h080;
localparam [9:0] S_ZSR = 10'h100;
localparam [9:0] S_HW = 10'h200;
// -------------------------------------------------------------
// loaded tables and working memories
// -------------------------------------------------------------
reg signed [15:0] ci [0:1023];
reg [15:0] gi [0:1023];
reg [7:0] pk [0:31];
reg [3:0] pn [0:3];
reg [31:0] r0 [0:3];
reg signed [15:0] c0 [0:3];
reg [15:0] g0 [0:3];
reg signed [15:0] cp [0:3];
reg [15:0] gp [0:3];
reg [10:0] lp [0:3];
reg [10:0] lt [0:255];
reg signed [15:0] cf [0:95];
reg signed [15:0] hh [0:159];
reg signed [15:0] xw [0:159];
reg signed [15:0] zr [0:159];
reg signed [15:0] hs [0:215];
reg signed [15:0] gb [0:39];
reg signed [15:0] b1 [0:39];
reg signed [15:0] acb_o [0:159];
reg signed [15:0] bpp_o [0:159];
reg signed [15:0] p_o [0:159];
reg [7:0] sl [0:31];
reg signed [39:0] se [0:7];
reg [7:0] tl [0:3];
// control state
reg [9:0] st;
reg [1:0] m, ac, cs, cm, ck;
reg dir, fr, fin, done_r;
reg [7:0] lv, bl, blv;
reg signed [15:0] bc;
reg [15:0] bg;
reg signed [39:0] acc, zacc;
reg [3:0] nt;
reg [31:0] cx, trv, clv;
reg [1:0] mode_r;
reg [5:0] n, k;
reg signed [47:0] cacc, gacc, bcc, bgc;
integer i1, i2, i3, i4, i5;
// -------------------------------------------------------------
// arithmetic helpers
// -------------------------------------------------------------
// c/sqrt(g) > cb/sqrt(gb) by cross-multiplying signed squares
function better;
   input signed [47:0] c, g, cb, gb;
   reg signed [143:0] l, r;
   begin
      l = c * c * gb;
      r = cb * cb * g;
      if (c < 0) l = -l;
      if (cb < 0) r = -r;
      better = l > r;
   end
endfunction
// open-loop residual energy r - c*c/g
function signed [33:0] er;
   input [31:0] r;
   input signed [15:0] c;
   input [15:0] g;
   reg signed [31:0] p;
   begin
      p = c * c;
      er = $signed({2'b00, r});
      if (g != 16'h0000) er = er - p / $signed({16'h0000, g});
   end
endfunction
// extended excitation: history below zero, new samples above
function signed [15:0] ext;
   input integer e;
   begin
      if (e < `HOFF) ext = hs[e];
      else ext = gb[e - `HOFF];
   end
endfunction
// harmonic filter input: target difference or filtered vector
function signed [15:0] hx;
   input t; // target select, passed in so the caller wakes on state changes
   input integer s;
   reg signed [16:0] d;
   begin
      d = xw[cm * `NS + s] - zr[cm * `NS + s];
      if (s < 0) hx = 16'h0000;
      else if (t) hx = d[15:0];
      else hx = b1[s];
   end
endfunction
// -------------------------------------------------------------
// trajectory search datapath
// -------------------------------------------------------------
reg af;
reg [2:0] ai;
reg [7:0] rf, dn, up, wlo, whi, v, wv;
reg wt;
reg signed [15:0] wc;
reg [15:0] wg;
reg [31:0] hit;
// highest uncrossed peak of the anchor subframe
always @* begin
   af = 1'b0;
   ai = 3'h0;
   for (i1 = 0; i1 < 8; i1 = i1 + 1)
      if (i1 < pn[m] && !cx[{m, i1[2:0]}] && (!af ||
          better(ci[{m, pk[{m, i1[2:0]}]}], gi[{m, pk[{m, i1[2:0]}]}],
                 ci[{m, pk[{m, ai}]}], gi[{m, pk[{m, ai}]}]))) begin
         af = 1'b1;
         ai = i1[2:0];
      end
end
// clipped search window and running winner
always @* begin
   rf = dir ? tl[cs + 2'd1] : tl[cs - 2'd1];
   dn = dir ? `BW_DN : `FW_DN;
   up = dir ? `BW_UP : `FW_UP;
   wlo = ({1'b0, rf} < {1'b0, `LV_LO} + {1'b0, dn}) ? `LV_LO : rf - dn;
   whi = ({1'b0, rf} + {1'b0, up} > {1'b0, `LV_HI}) ? `LV_HI : rf + up;
   v = fr ? wlo : lv;
   wt = fr || better(ci[{cs, v}], gi[{cs, v}], bc, bg);
   wv = wt ? v : bl;
   wc = wt ? ci[{cs, v}] : bc;
   wg = wt ? gi[{cs, v}] : bg;
   for (i2 = 0; i2 < 32; i2 = i2 + 1)
      hit[i2] = pk[i2] == tl[i2 / 8];
end
// -------------------------------------------------------------
// selection, gains and mode
// -------------------------------------------------------------
reg [2:0] bt;
reg signed [47:0] sr, sres, rs;
reg lo35, lo70, f17;
reg [1:0] md;
always @* begin
   bt = 3'h0;
   for (i3 = 1; i3 < 8; i3 = i3 + 1)
      if (i3 < nt && se[i3] < se[bt]) bt = i3[2:0];
   sr = 48'h0;
   sres = 48'h0;
   lo35 = 1'b0;
   lo70 = 1'b0;
   for (i3 = 0; i3 < 4; i3 = i3 + 1) begin
      rs = er(r0[i3], ci[{i3[1:0], trv[i3 * 8 +: 8]}],
              gi[{i3[1:0], trv[i3 * 8 +: 8]}]);
      sr = sr + $signed({16'h0000, r0[i3]});
      sres = sres + er(r0[i3], c0[i3], g0[i3]);
      if (rs > 0 && ($signed({16'h0000, r0[i3]}) <<< 8) < $signed({1'b0, `K35}) * rs)
         lo35 = 1'b1;
      if (rs > 0 && ($signed({16'h0000, r0[i3]}) <<< 8) < $signed({1'b0, `K70}) * rs)
         lo70 = 1'b1;
   end
   f17 = sres > 0 && (sr <<< 8) < $signed({1'b0, `K17}) * sres;
   md = f17 ? 2'd0 : lo35 ? 2'd1 : lo70 ? 2'd2 : 2'd3;
end
// -------------------------------------------------------------
// adaptive codebook, harmonic weighting, closed-loop metric
// -------------------------------------------------------------
reg [7:0] tc, cl;
reg [1:0] ck0, ckl;
reg [15:0] l6, k6, q6, la, jp, li, jj;
reg signed [39:0] gs, hsum, zs;
reg signed [15:0] gsm, hv, x0, y;
reg signed [31:0] lm;
reg signed [47:0] tt, cn, gn;
integer sb, sbk;
always @* begin
   tc = trv[{cm, 3'b000} +: 8];
   ck0 = (tc == `LV_LO) ? 2'd1 : 2'd0;
   ckl = (tc == `LV_HI) ? 2'd1 : 2'd2;
   cl = fin ? blv : tc + {6'h00, ck} - 8'h01;
   sb = cm * `NS + n;
   sbk = cm * `NS + k;
   // fractional delay in sixths, filter phase from it
   l6 = {5'h00, lt[cl]};
   k6 = (16'd6 * {10'h000, n} + l6 + 16'd5) / l6;
   q6 = k6 * l6;
   la = q6 / 16'd6;
   jp = q6 % 16'd6;
   gs = 40'h0;
   if (jp == 16'h0000) gs = ext(n + `HOFF - la) <<< 15;
   else for (i4 = 0; i4 < 10; i4 = i4 + 1)
      gs = gs + cf[jp * 10 + i4] * ext(n + `HOFF - la - 5 + i4);
   gsm = gs[30:15];
   zs = zacc + hh[sbk] * gb[n - k];
   // harmonic weighting coefficient and delayed input
   lm = 32'h0;
   if (gp[cm] != 16'h0000)
      lm = (cp[cm] * $signed(`LAM_K)) / $signed({16'h0000, gp[cm]});
   li = {5'h00, lp[cm]} / 16'd6;
   jj = {5'h00, lp[cm]} % 16'd6;
   hsum = 40'h0;
   for (i5 = 0; i5 < 6; i5 = i5 + 1)
      hsum = hsum + cf[`GOFF + jj * 6 + i5] * hx(st == S_TGT, n - li - 3 + i5);
   hv = hsum[30:15];
   x0 = hx(st == S_TGT, n);
   tt = lm * hv;
   y = (mode_r == 2'd0) ? x0 : x0 - tt[30:15];
   cn = cacc + y * p_o[sb];
   gn = gacc + y * y;
end
// -------------------------------------------------------------
// control sequencer
// -------------------------------------------------------------
// frame sequence: trajectories, selection, mode, closed loop
always @(posedge clk or posedge sys_rst) begin
   if (sys_rst) begin
      st <= S_IDLE;
      m <= 2'd0;
      ac <= 2'd0;
      cs <= 2'd0;
      cm <= 2'd0;
      ck <= 2'd0;
      dir <= 1'b0;
      fr <= 1'b0;
      fin <= 1'b0;
      done_r <= 1'b0;
      lv <= 8'h00;
      bl <= 8'h00;
      blv <= 8'h00;
      bc <= 16'h0000;
      bg <= 16'h0000;
      acc <= 40'h0;
      zacc <= 40'h0;
      nt <= 4'h0;
      cx <= 32'h0;
      trv <= 32'h0;
      clv <= 32'h0;
      mode_r <= 2'd0;
      n <= 6'h00;
      k <= 6'h00;
      cacc <= 48'h0;
      gacc <= 48'h0;
      bcc <= 48'h0;
      bgc <= 48'h0;
   end else begin
      case (st)
         S_IDLE: if (start) begin
            done_r <= 1'b0;
            m <= 2'd0;
            ac <= 2'd0;
            nt <= 4'h0;
            cx <= 32'h0;
            st <= S_ANC;
         end
         S_ANC: if (!af || ac == 2'd2) begin
            ac <= 2'd0;
            if (m == 2'd3) st <= S_SEL;
            else m <= m + 2'd1;
         end else begin
            ac <= ac + 2'd1;
            acc <= er(r0[m], ci[{m, pk[{m, ai}]}], gi[{m, pk[{m, ai}]}]);
            fr <= 1'b1;
            dir <= (m == 2'd3);
            cs <= (m == 2'd3) ? m - 2'd1 : m + 2'd1;
            st <= S_WIN;
         end
         S_WIN: begin
            lv <= v + 8'h01;
            fr <= 1'b0;
            bl <= wv;
            bc <= wc;
            bg <= wg;
            if (v == whi) begin
               acc <= acc + er(r0[cs], wc, wg);
               fr <= 1'b1;
               if (!dir && cs != 2'd3) cs <= cs + 2'd1;
               else if (!dir && m != 2'd0) begin
                  dir <= 1'b1;
                  cs <= m - 2'd1;
               end else if (dir && cs != 2'd0) cs <= cs - 2'd1;
               else st <= S_STO;
            end
         end
         S_STO: begin
            nt <= nt + 4'h1;
            cx <= cx | hit;
            st <= S_ANC;
         end
         S_SEL: begin
            if (nt != 4'h0) trv <= {sl[{bt, 2'd3}], sl[{bt, 2'd2}], sl[{bt, 2'd1}],
                                   sl[{bt, 2'd0}]};
            else trv <= 32'h0; // no trajectory leaves all lags at zero
            st <= S_MOD;
         end
         S_MOD: begin
            mode_r <= md;
            cm <= 2'd0;
            n <= 6'h00;
            st <= S_TGT;
         end
         S_TGT: begin
            n <= n + 6'h01;
            if (n == `NS - 1) begin
               n <= 6'h00;
               if (mode_r == 2'd0) begin
                  clv[{cm, 3'b000} +: 8] <= tc;
                  if (cm == 2'd3) begin
                     done_r <= 1'b1;
                     st <= S_IDLE;
                  end else cm <= cm + 2'd1;
               end else begin
                  ck <= ck0;
                  fin <= 1'b0;
                  st <= S_GEN;
               end
            end
         end
         S_GEN: begin
            n <= n + 6'h01;
            if (n == `NS - 1) begin
               n <= 6'h00;
               k <= 6'h00;
               zacc <= 40'h0;
               st <= S_ZSR;
            end
         end
         S_ZSR: if (k == n) begin
            zacc <= 40'h0;
            k <= 6'h00;
            n <= n + 6'h01;
            if (n == `NS - 1) begin
               n <= 6'h00;
               cacc <= 48'h0;
               gacc <= 48'h0;
               st <= S_HW;
            end
         end else begin
            zacc <= zs;
            k <= k + 6'h01;
         end
         S_HW: begin
            cacc <= cn;
            gacc <= gn;
            n <= n + 6'h01;
            if (n == `NS - 1) begin
               n <= 6'h00;
               if (fin) begin
                  clv[{cm, 3'b000} +: 8] <= blv;
                  st <= S_TGT;
                  if (cm == 2'd3) begin
                     done_r <= 1'b1;
                     st <= S_IDLE;
                  end else cm <= cm + 2'd1;
               end else begin
                  if (ck == ck0 || better(cn, gn, bcc, bgc)) begin
                     blv <= cl;
                     bcc <= cn;
                     bgc <= gn;
                  end
                  if (ck == ckl) fin <= 1'b1;
                  else ck <= ck + 2'd1;
                  st <= S_GEN;
               end
            end
         end
         default: st <= S_IDLE;
      endcase
   end
end
// -------------------------------------------------------------
// memory writes and read port
// -------------------------------------------------------------
// upstream table loads
always @(posedge clk) begin
   if (wr_en) begin
      case (wr_sel)
         `W_CI: ci[wr_addr] <= wr_data[15:0];
         `W_GI: gi[wr_addr] <= wr_data[15:0];
         `W_PK: pk[wr_addr[4:0]] <= wr_data[7:0];
         `W_PN: pn[wr_addr[1:0]] <= wr_data[3:0];
         `W_R0: r0[wr_addr[1:0]] <= wr_data;
         `W_C0: c0[wr_addr[1:0]] <= wr_data[15:0];
         `W_G0: g0[wr_addr[1:0]] <= wr_data[15:0];
         `W_CP: cp[wr_addr[1:0]] <= wr_data[15:0];
         `W_GP: gp[wr_addr[1:0]] <= wr_data[15:0];
         `W_LP: lp[wr_addr[1:0]] <= wr_data[10:0];
         `W_LT: lt[wr_addr[7:0]] <= wr_data[10:0];
         `W_CF: cf[wr_addr[6:0]] <= wr_data[15:0];
         `W_HH: hh[wr_addr[7:0]] <= wr_data[15:0];
         `W_XW: xw[wr_addr[7:0]] <= wr_data[15:0];
         `W_ZR: zr[wr_addr[7:0]] <= wr_data[15:0];
         default: hs[wr_addr[7:0]] <= wr_data[15:0];
      endcase
   end
end
// working memories written by the sequencer
always @(posedge clk) begin
   if (st == S_ANC && af && ac != 2'd2) tl[m] <= pk[{m, ai}];
   if (st == S_WIN && v == whi) tl[cs] <= wv;
   if (st == S_STO) begin
      sl[{nt[2:0], 2'd0}] <= tl[0];
      sl[{nt[2:0], 2'd1}] <= tl[1];
      sl[{nt[2:0], 2'd2}] <= tl[2];
      sl[{nt[2:0], 2'd3}] <= tl[3];
      se[nt[2:0]] <= acc;
   end
   if (st == S_TGT) p_o[sb] <= y;
   if (st == S_GEN) begin
      gb[n] <= gsm;
      if (fin) acb_o[sb] <= gsm;
   end
   if (st == S_ZSR && k == n) b1[n] <= zs[30:15];
   if (st == S_HW && fin) bpp_o[sb] <= y;
end
// registered result read
always @(posedge clk or posedge sys_rst) begin
   if (sys_rst) rd_data <= 16'h0000;
   else if (rd_sel == `R_ACB) rd_data <= acb_o[rd_addr];
   else if (rd_sel == `R_BPP) rd_data <= bpp_o[rd_addr];
   else rd_data <= p_o[rd_addr];
end
assign busy = st != S_IDLE;
assign done = done_r;
assign mode = mode_r;
assign traj_lags = trv;
assign cl_lags = clv;
assign traj_count = nt;
endmodule

// ===== bench/pitch_lag_checker_assertions.sv
// checker: handshake, hold and lag relations of the lag search stage
// assumes it is bound to the stage's top module on its single clock
`timescale 1ns/1ps
module pitch_lag_checker (
   input wire clk,
   input wire sys_rst,
   input wire start,
   input wire busy,
   input wire done,
   input wire [1:0] mode,
   input wire [31:0] traj_lags,
   input wire [31:0] cl_lags,
   input wire [3:0] traj_count
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // --------------------------------
   // helper logic
   // --------------------------------
   reg [15:0] run_reg;
   // cycles spent in the current frame
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         run_reg <= 16'h0000;
      else if (!busy)
         run_reg <= 16'h0000;
      else
         run_reg <= run_reg + 16'h0001;
   end
   // each of the lowest n byte pairs of a and b within plus or minus w levels
   function automatic bit near(input [31:0] a, input [31:0] b, input integer n,
                               input integer w);
      integer i, d;
      begin
         near = 1'b1;
         for (i = 0; i < n; i = i + 1) begin
            d = a[8*i +: 8] - b[8*i +: 8];
            if (d < -w || d > w)
               near = 1'b0;
         end
      end
   endfunction
   // --------------------------------
   // assertions
   // --------------------------------
   AST_START_TAKEN: assert property (
      start && !busy |=> busy && !done) else $error("start not taken");
   AST_LAGS_HOLD: assert property (
      done && !start |=> done && $stable(traj_lags) && $stable(cl_lags))
      else $error("lags moved while done");
   AST_MODE_HOLD: assert property (
      done && !start |=> $stable(mode) && $stable(traj_count)) else $error("mode moved");
   AST_DONE_IDLE: assert property (done |-> !busy) else $error("done while busy");
   AST_COUNT_MAX: assert property (
      $rose(done) |-> traj_count <= 4'h8) else $error("too many trajectories");
   AST_MODE0_COPY: assert property (
      $rose(done) && mode == 2'h0 |-> cl_lags == traj_lags) else $error("mode 0 lags");
   AST_CL_NEAR: assert property (
      $rose(done) && mode != 2'h0 |-> near(cl_lags, traj_lags, 4, 1))
      else $error("closed loop lag off");
   AST_TRAJ_STEP: assert property (
      $rose(done) |-> near(traj_lags >> 8, traj_lags, 3, 7)) else $error("lag step");
   AST_EMPTY_ZERO: assert property (
      $rose(done) && traj_count == 4'h0 |-> traj_lags == 32'h0) else $error("empty lags");
   AST_FRAME_BOUND: assert property (
      busy |-> run_reg < 16'h9C40) else $error("frame too long");
   cover property ($rose(done) && mode == 2'h0);
   cover property ($rose(done) && mode == 2'h3);
   cover property (start && busy);
endmodule
bind pitch_lag_search_mode_select pitch_lag_checker u_chk (
   .clk(clk),
   .sys_rst(sys_rst),
   .start(start),
   .busy(busy),
   .done(done),
   .mode(mode),
   .traj_lags(traj_lags),
   .cl_lags(cl_lags),
   .traj_count(traj_count)
);

// ===== bench/upstream_feeder.sv
// upstream model: loads peaks, energies and filter tables, then starts a frame
// assumes the stage takes table words on the rising edge
`timescale 1ns/1ps
`include "pitch_lag_regs.vh"
module upstream_feeder (
   input wire clk,
   output reg wr_en,
   output reg [3:0] wr_sel,
   output reg [9:0] wr_addr,
   output reg [31:0] wr_data,
   output reg start
);
   // idle levels at time zero
   initial begin
      wr_en = 1'b0;
      wr_sel = 4'h0;
      wr_addr = 10'h000;
      wr_data = 32'h0;
      start = 1'b0;
   end
   // one table word per cycle, changed at the falling edge
   task put(input [3:0] s, input integer a, input integer d);
      begin
         @(negedge clk);
         wr_en = 1'b1;
         wr_sel = s;
         wr_addr = a[9:0];
         wr_data = d;
      end
   endtask
   // whole frame; peaks only in subframe sa, uniform correlation tables
   task load_frame(input integer npk, input integer sa, input [7:0] base,
                   input integer cp, input integer ci);
      integer m, i;
      begin
         for (m = 0; m < 4; m = m + 1) begin
            put(`W_PN, m, (m == sa) ? npk : 0);
            for (i = 0; i < npk; i = i + 1)
               put(`W_PK, m * 8 + i, (base + i * 37) % 256);
            put(`W_R0, m, 1000);
            put(`W_C0, m, cp);
            put(`W_G0, m, 1000);
            put(`W_CP, m, 0);
            put(`W_GP, m, 1000);
            put(`W_LP, m, 240);
            for (i = 0; i < 256; i = i + 1) begin
               put(`W_CI, m * 256 + i, ci);
               put(`W_GI, m * 256 + i, 1000);
            end
            for (i = 0; i < 40; i = i + 1) begin
               put(`W_HH, m * 40 + i, 0);
               put(`W_XW, m * 40 + i, 256 + i);
               put(`W_ZR, m * 40 + i, 2 * i);
            end
         end
         for (i = 0; i < 256; i = i + 1)
            put(`W_LT, i, 120 + 4 * i);
         for (i = 0; i < 216; i = i + 1)
            put(`W_HS, i, 256);
         for (i = 0; i < 96; i = i + 1)
            put(`W_CF, i, 0);
         @(negedge clk);
         wr_en = 1'b0;
         wr_data = ~wr_data;
      end
   endtask
   // one-cycle start once all tables are valid
   task fire;
      begin
         @(negedge clk);
         start = 1'b1;
         @(negedge clk);
         start = 1'b0;
      end
   endtask
endmodule

// ===== bench/pitch_lag_search_mode_select_bench.sv
// self-checking bench of the lag search and voicing mode stage
// assumes the upstream model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "pitch_lag_regs.vh"
module pitch_lag_search_mode_select_bench;
   reg clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [1:0] rd_sel = 2'h0;
   reg [7:0] rd_addr = 8'h00;
   wire start, wr_en, busy, done;
   wire [3:0] wr_sel, traj_count;
   wire [9:0] wr_addr;
   wire [31:0] wr_data, traj_lags, cl_lags;
   wire [15:0] rd_data;
   wire [1:0] mode;
   integer errors = 0;
   integer n_tests = 0;
   reg [15:0] rnd = 16'h0045;
   integer vals [0:5];
   reg [23:0] corner [0:3];
   // 40 MHz clock
   always #12.5 clk = ~clk;
   upstream_feeder up (.clk(clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_addr(wr_addr),
      .wr_data(wr_data), .start(start));
   pitch_lag_search_mode_select dut (.clk(clk), .sys_rst(sys_rst), .start(start),
      .wr_en(wr_en), .wr_sel(wr_sel), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_sel(rd_sel), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy), .done(done),
      .mode(mode), .traj_lags(traj_lags), .cl_lags(cl_lags), .traj_count(traj_count));
   // --------------------------------
   // checking and expectation helpers
   // --------------------------------
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, errors);
         if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task chk_eq(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   task chk_ok(input ok);
      begin
         n_tests = n_tests + 1;
         if (ok !== 1'b1) begin
            errors = errors + 1;
            $display("BAD %0t lag relation broken %h", $time, traj_lags);
         end
      end
   endtask
   // read port answers one cycle after the address
   task rd(input [1:0] s, input integer a, output [15:0] v);
      begin
         @(negedge clk);
         rd_sel = s;
         rd_addr = a[7:0];
         @(negedge clk);
         v = rd_data;
      end
   endtask
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // mode from frame and subframe gains in decibels, G fixed at 1000
   function [1:0] exp_mode(input integer cp, input integer cs);
      real pv, pm;
      begin
         pv = 10.0 * $log10(1000.0 / (1000.0 - cp * cp / 1000.0));
         pm = 10.0 * $log10(1000.0 / (1000.0 - cs * cs / 1000.0));
         if (pv < 1.7)
            exp_mode = 2'h0;
         else if (pm < 3.5)
            exp_mode = 2'h1;
         else if (pm < 7.0)
            exp_mode = 2'h2;
         else
            exp_mode = 2'h3;
      end
   endfunction
   // integer lags copy the flat history level, fractional ones meet zero taps
   function [15:0] exp_acb(input [7:0] lv);
      exp_acb = ((120 + 4 * lv) % 6) ? 16'h0000 : 16'h0100;
   endfunction
   // forward steps -7..+6 after the anchor, backward -6..+7 before it
   function steps_ok(input [31:0] t, input integer sa);
      integer m, d;
      begin
         steps_ok = 1'b1;
         for (m = 1; m < 4; m = m + 1) begin
            d = t[8*m +: 8] - t[8*m-8 +: 8];
            if (m > sa && (d < -7 || d > 6))
               steps_ok = 1'b0;
            if (m <= sa && (d < -7 || d > 6))
               steps_ok = 1'b0;
         end
      end
   endfunction
   function anchor_ok(input [7:0] lv, input [7:0] b, input integer n);
      integer i;
      begin
         anchor_ok = 1'b0;
         for (i = 0; i < n; i = i + 1)
            if (lv === 8'(b + i * 37))
               anchor_ok = 1'b1;
      end
   endfunction
   // --------------------------------
   // main sequence
   // --------------------------------
   initial begin : main
      integer k, npk, sa, cpi, csi, i;
      reg [7:0] base;
      reg [15:0] v;
      vals[0] = 0;
      vals[1] = 316;
      vals[2] = 548;
      vals[3] = 707;
      vals[4] = 775;
      vals[5] = 949;
      corner[0] = 24'h200000;
      corner[1] = 24'h33FF52;
      corner[2] = 24'h12FA54;
      corner[3] = 24'h030035;
      repeat (10) @(negedge clk);
      sys_rst = 1'b0;
      chk_eq({done, busy, traj_count}, 0);
      for (k = 0; k < 5; k = k + 1) begin
         rnd = lfsr(rnd);
         npk = corner[k % 4][23:20];
         sa = corner[k % 4][19:16];
         base = corner[k % 4][15:8];
         cpi = corner[k % 4][7:4];
         csi = corner[k % 4][3:0];
         if (k == 4) begin
            npk = rnd[1:0];
            sa = rnd[2] ? 3 : 0;
            base = rnd[15:8];
            cpi = rnd[6:3] % 6;
            csi = rnd[10:7] % 6;
         end
         up.load_frame(npk, sa, base, vals[cpi], vals[csi]);
         up.fire;
         repeat (3) @(negedge clk);
         up.fire;
         for (i = 0; i < 40000 && done !== 1'b1; i = i + 1)
            @(negedge clk);
         if (done !== 1'b1) begin
            errors = errors + 1;
            $display("BAD %0t frame never finished", $time);
            summarize;
         end
         chk_eq(mode, exp_mode(vals[cpi], vals[csi]));
         chk_eq(traj_count, (npk > 2) ? 2 : npk);
         chk_ok(steps_ok(traj_lags, sa));
         if (npk == 0)
            chk_eq(traj_lags, 0);
         else
            chk_ok(anchor_ok(traj_lags[8*sa +: 8], base, npk));
         for (i = 0; i < 160; i = i + 53) begin
            if (mode === 2'h0) begin
               rd(`R_TGT, i, v);
               chk_eq(v, 16'h0100 - i % 40);
            end else begin
               rd(`R_ACB, i, v);
               chk_eq(v, exp_acb(cl_lags[8 * (i / 40) +: 8]));
               rd(`R_BPP, i, v);
               chk_eq(v, 0);
            end
         end
         if (mode === 2'h0)
            chk_eq(cl_lags, traj_lags);
         $display("frame %0d mode %0d trajectories %0d", k, mode, traj_count);
      end
      @(negedge clk);
      sys_rst = 1'b1;
      @(negedge clk);
      chk_eq({done, busy, traj_count, mode}, 0);
      chk_eq(traj_lags | cl_lags, 0);
      sys_rst = 1'b0;
      summarize;
   end
endmodule
